/* File: hw/ofp_autobaud.sv */
// Boot-link bit rate measurement from the host's first low frame.
module ofp_autobaud
  import ofp_pkg::*;
#(
  parameter int CNT_W = 20
)(
  // Clock and reset.
  input  wire logic             ref_clk,
  input  wire logic             reset,
  // Link.
  input  wire logic             enable,
  input  wire logic             boot_serial_rx,
  // Result.
  output logic                  locked,
  output logic [CNT_W-1:0]      bit_period
);

  generate
    if (CNT_W < 8) begin : g_bad_width
      $error("CNT_W too small for a bit period count");
    end
  endgenerate

  ofp_baud_e        st;
  logic [CNT_W-1:0] low_cnt;

  // The host sends a zero byte, so start plus data bits give one low run.
  always_ff @(posedge ref_clk)
  begin
    if (reset || !enable) begin
      st         <= AB_ARM;
      low_cnt    <= '0;
      bit_period <= '0;
    end else begin
      case (st)
        AB_ARM:
        begin
          if (boot_serial_rx) st <= AB_IDLE;
        end
        AB_IDLE:
        begin
          if (!boot_serial_rx) begin
            st      <= AB_LOW;
            low_cnt <= CNT_W'(1);
          end
        end
        AB_LOW:
        begin
          if (!boot_serial_rx) begin
            low_cnt <= low_cnt + CNT_W'(1);
          end else if (low_cnt < CNT_W'(BAUD_LOW_BITS)) begin
            // Glitches shorter than one clock per bit are dropped.
            st <= AB_IDLE;
          end else begin
            bit_period <= low_cnt / CNT_W'(BAUD_LOW_BITS); // [RULE_12]
            st         <= AB_LOCK;
          end
        end
        default:
        begin
          st <= AB_LOCK;
        end
      endcase
    end
  end

  assign locked = (st == AB_LOCK);

  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  baud_match_a: assert property ( // [RULE_12]
    (st == AB_LOW) && enable && boot_serial_rx
      && (low_cnt >= CNT_W'(BAUD_LOW_BITS))
    |=> locked && (bit_period == $past(low_cnt) / CNT_W'(BAUD_LOW_BITS)))
    else $error("bit period does not follow the measured low run");

  lock_hold_a: assert property ( // [RULE_12]
    locked && enable |=> locked && $stable(bit_period))
    else $error("locked bit rate changed while boot link enabled");

endmodule : ofp_autobaud

/* File: hw/ofp_flash_ctrl.sv */
// Program/erase sequencer and array for the 64-kbyte on-chip flash.
// What this block does
// RULE_01 - Programming always writes a full unit of 128 consecutive bytes.
// RULE_02 - Erase clears exactly one whole block; no single-byte erase exists.
// RULE_03 - Array split into two 8k, one 16k, one 28k, four 1k blocks.
// RULE_04 - Software clears the whole array in user program mode block by block.
// RULE_05 - Each 128-byte unit starts at low address byte 00 or 80.
// RULE_06 - Plain user mode allows reads but blocks programming and erasing.
// RULE_07 - Mode comes from the strap pins held during reset, active after release.
// RULE_08 - Boot mode erases the whole array at once, never single blocks.
// RULE_09 - User program mode erases and programs individually chosen blocks.
// RULE_10 - Erased bytes read back as all ones.
// RULE_11 - Flash control bits are writable only while register enable is 1.
// RULE_12 - Boot mode measures the host bit rate and matches it.
// RULE_13 - Boot first checks the link, then loads the erase routine.
// RULE_14 - Software programs only erased blocks.
// RULE_15 - Hardware, software and error conditions each protect the array.
// RULE_16 - Under any protection, start requests are ignored and array unchanged.
// RULE_17 - Write enable resets to 0 and, while 0, nothing can start.
module ofp_flash_ctrl
  import ofp_pkg::*;
#(
  parameter int BAUD_CNT_W = 20,
  parameter int COPY_CYC   = COPY_CYCLES
)(
  // Clock and reset.
  input  wire logic             ref_clk,
  input  wire logic             reset,
  // Mode straps.
  input  wire logic             mode_select_pin_1,
  input  wire logic             mode_select_pin_0,
  input  wire logic             aux_mode_pin_2,
  input  wire logic             aux_mode_pin_1,
  input  wire logic             aux_mode_pin_0,
  // Boot serial link.
  input  wire logic             boot_serial_rx,
  output logic                  boot_serial_tx,
  // Write enable control.
  input  wire logic             flash_reg_enable,
  input  wire logic             swe_wr,
  input  wire logic             swe_wdata,
  // Commands.
  input  wire logic             cmd_valid,
  input  wire logic [1:0]       cmd_op,
  input  wire logic [2:0]       cmd_block,
  input  wire logic [8:0]       cmd_page,
  output logic                  cmd_ready,
  output logic                  cmd_refused,
  output logic                  op_done,
  // Program data.
  input  wire logic             pd_valid,
  input  wire logic [7:0]       pd_data,
  output logic                  pd_ready,
  // Read port.
  input  wire logic [15:0]      rd_addr,
  output logic [7:0]            rd_data,
  // Status.
  output ofp_mode_e             mode,
  output logic                  software_write_enable,
  output logic                  flash_error,
  output logic                  boot_ready,
  output logic                  baud_locked,
  output logic [BAUD_CNT_W-1:0] baud_period
);

  generate
    if (COPY_CYC < 1 || COPY_CYC > 255) begin : g_bad_copy
      $error("COPY_CYC must lie in 1..255");
    end
  endgenerate

  logic [7:0]  mem [0:65535];
  logic [7:0]  page_buf [0:PAGE_BYTES-1];
  ofp_state_e  st;
  ofp_mode_e   next_mode;
  logic [15:0] wr_addr;
  logic [15:0] hi_addr;
  logic [6:0]  pcnt;
  logic        unerased;
  logic        unerased_now;
  logic [7:0]  copy_cnt;
  logic        prot;
  logic        op_ok;
  logic        accept;
  logic        mem_we;
  logic [15:0] mem_waddr;
  logic [7:0]  mem_wdata;
  logic [15:0] unit_addr;

  // Strap decode: mode lines pick the programmer, aux lines the rest.
  always_comb
  begin
    if ({mode_select_pin_1, mode_select_pin_0} == MD_PROGRAMMER) begin
      next_mode = MODE_PROGRAMMER;
    end else if ({aux_mode_pin_2, aux_mode_pin_1, aux_mode_pin_0}
                 == AUX_BOOT) begin
      next_mode = MODE_BOOT;
    end else if ({aux_mode_pin_2, aux_mode_pin_1, aux_mode_pin_0}
                 == AUX_UPROG) begin
      next_mode = MODE_UPROG;
    end else begin
      next_mode = MODE_USER;
    end
  end

  // Straps are followed while reset is held and frozen at its release.
  always_ff @(posedge ref_clk)
  begin
    if (reset) mode <= next_mode; // [RULE_07]
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset) begin
      software_write_enable <= SWE_RESET; // [RULE_17]
    end else if (swe_wr && flash_reg_enable) begin
      software_write_enable <= swe_wdata; // [RULE_11]
    end
  end

  ofp_autobaud #(
    .CNT_W          (BAUD_CNT_W)
  ) u_autobaud (
    .ref_clk        (ref_clk),
    .reset          (reset),
    .enable         (mode == MODE_BOOT),
    .boot_serial_rx (boot_serial_rx),
    .locked         (baud_locked),
    .bit_period     (baud_period)
  );

  // The erase routine copy is only timed here; the RAM itself lies outside.
  always_ff @(posedge ref_clk)
  begin
    if (reset) begin
      copy_cnt   <= 8'h00;
      boot_ready <= 1'b0;
    end else if (baud_locked && !boot_ready) begin // [RULE_13]
      copy_cnt   <= copy_cnt + 8'h01;
      boot_ready <= (copy_cnt == 8'(COPY_CYC - 1));
    end
  end

  assign boot_serial_tx = 1'b1;

  // Hardware, software and error protection in one term.
  assign prot = (mode == MODE_USER) || !software_write_enable // [RULE_15]
                || flash_error;

  always_comb
  begin
    case (cmd_op)
      OP_PROGRAM:   op_ok = (mode != MODE_BOOT) || boot_ready;
      OP_BLK_ERASE: op_ok = (mode == MODE_UPROG); // [RULE_08] [RULE_09]
      OP_ALL_ERASE: op_ok = (mode == MODE_PROGRAMMER)
                            || ((mode == MODE_BOOT) && boot_ready);
      default:      op_ok = 1'b0;
    endcase
  end

  assign cmd_ready = (st == ST_IDLE);
  assign accept    = cmd_valid && cmd_ready && !prot && op_ok; // [RULE_16]
  assign pd_ready  = (st == ST_LOAD);
  assign unit_addr = {wr_addr[15:7], pcnt};
  assign unerased_now = (mem[unit_addr] != ERASED_BYTE); // [RULE_14]

  always_ff @(posedge ref_clk)
  begin
    if (reset) begin
      st       <= ST_IDLE;
      wr_addr  <= 16'h0000;
      hi_addr  <= 16'h0000;
      pcnt     <= 7'h00;
      unerased <= 1'b0;
    end else begin
      case (st)
        ST_IDLE:
        begin
          pcnt     <= 7'h00;
          unerased <= 1'b0;
          if (accept && cmd_op == OP_PROGRAM) begin
            st      <= ST_LOAD;
            wr_addr <= {cmd_page, 7'h00}; // [RULE_05]
          end else if (accept && cmd_op == OP_BLK_ERASE) begin
            st      <= ST_ERASE;
            wr_addr <= BLK_LO[cmd_block]; // [RULE_02] [RULE_03]
            hi_addr <= BLK_HI[cmd_block];
          end else if (accept) begin
            st      <= ST_ERASE;
            wr_addr <= ARRAY_LO; // [RULE_08]
            hi_addr <= ARRAY_HI;
          end
        end
        ST_LOAD:
        begin
          if (pd_valid) begin
            pcnt     <= pcnt + 7'h01;
            unerased <= unerased || unerased_now;
            if (pcnt == PAGE_LAST) begin
              // Checking before writing keeps a bad unit from touching cells.
              st <= (unerased || unerased_now) ? ST_IDLE : ST_PROG;
            end
          end
        end
        ST_PROG:
        begin
          pcnt <= pcnt + 7'h01;
          if (pcnt == PAGE_LAST) st <= ST_IDLE; // [RULE_01]
        end
        default:
        begin
          wr_addr <= wr_addr + 16'h0001;
          if (wr_addr == hi_addr) st <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (st == ST_LOAD && pd_valid) page_buf[pcnt] <= pd_data;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset) begin
      flash_error <= 1'b0;
      op_done     <= 1'b0;
      cmd_refused <= 1'b0;
    end else begin
      if (st == ST_LOAD && pd_valid && pcnt == PAGE_LAST
          && (unerased || unerased_now)) begin
        flash_error <= 1'b1;
      end
      op_done <= (st == ST_PROG && pcnt == PAGE_LAST)
                 || (st == ST_ERASE && wr_addr == hi_addr);
      cmd_refused <= cmd_valid && cmd_ready && !accept; // [RULE_16]
    end
  end

  assign mem_we    = (st == ST_PROG) || (st == ST_ERASE); // [RULE_06]
  assign mem_waddr = (st == ST_PROG) ? unit_addr : wr_addr;
  assign mem_wdata = (st == ST_PROG) ? page_buf[pcnt] : ERASED_BYTE; // [RULE_10]

  always_ff @(posedge ref_clk)
  begin
    if (mem_we) mem[mem_waddr] <= mem_wdata;
  end

  always_ff @(posedge ref_clk)
  begin
    rd_data <= mem[rd_addr];
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_load_end;
    (st == ST_LOAD) && pd_valid && (pcnt == PAGE_LAST) && !unerased
      && !unerased_now;
  endsequence

  sequence s_full_unit;
    (st == ST_PROG && pcnt == 7'h00) ##127 (st == ST_PROG) ##1 (st == ST_IDLE);
  endsequence

  prog_unit_len_a: assert property (s_load_end |=> s_full_unit) // [RULE_01]
    else $error("program unit not 128 write cycles");

  unit_align_a: assert property ( // [RULE_05]
    $rose(st == ST_LOAD) |-> wr_addr[6:0] == 7'h00)
    else $error("program unit not aligned");

  user_no_write_a: assert property ( // [RULE_06]
    mode == MODE_USER |-> !mem_we && st == ST_IDLE)
    else $error("array written in user mode");

  erase_ones_a: assert property ( // [RULE_10]
    st == ST_ERASE |-> mem_we && mem_wdata == ERASED_BYTE)
    else $error("erase wrote a value other than all ones");

  blk_bounds_a: assert property ( // [RULE_02]
    accept && cmd_op == OP_BLK_ERASE
    |=> (wr_addr == BLK_LO[$past(cmd_block)])
        && (hi_addr == BLK_HI[$past(cmd_block)]) && st == ST_ERASE)
    else $error("block erase bounds wrong");

  boot_total_a: assert property ( // [RULE_08]
    mode == MODE_BOOT && $rose(st == ST_ERASE)
    |-> wr_addr == ARRAY_LO && hi_addr == ARRAY_HI)
    else $error("boot erase not the whole array");

  protect_ignore_a: assert property ( // [RULE_16]
    cmd_valid && cmd_ready && prot |=> st == ST_IDLE && cmd_refused)
    else $error("request started under protection");

  swe_gate_a: assert property ( // [RULE_11]
    swe_wr && !flash_reg_enable
    |=> $stable(software_write_enable))
    else $error("write enable changed with register access off");

  swe_reset_a: assert property ( // [RULE_17]
    !software_write_enable && cmd_ready |=> st == ST_IDLE)
    else $error("operation started with write enable low");

  boot_order_a: assert property ( // [RULE_13]
    $rose(boot_ready) |-> baud_locked)
    else $error("boot ready before the link was checked");

endmodule : ofp_flash_ctrl

/* File: hw/ofp_pkg.sv */
// Shared constants, modes and state types of the flash program/erase control.
package ofp_pkg;

  localparam int          ADDR_W        = 16;
  localparam int          PAGE_BYTES    = 128;
  localparam logic [6:0]  PAGE_LAST     = 7'h7f;
  localparam logic [7:0]  ERASED_BYTE   = 8'hff;
  localparam logic [15:0] ARRAY_LO      = 16'h0000;
  localparam logic [15:0] ARRAY_HI      = 16'hffff;
  localparam logic        SWE_RESET     = 1'b0;
  localparam int          BAUD_LOW_BITS = 9;
  localparam int          COPY_CYCLES   = 16;

  // Block map, block 0 in the low lanes: four 1k, one 28k, one 16k, two 8k.
  localparam logic [7:0][15:0] BLK_LO = {16'he000, 16'hc000, 16'h8000,
    16'h1000, 16'h0c00, 16'h0800, 16'h0400, 16'h0000};
  localparam logic [7:0][15:0] BLK_HI = {16'hffff, 16'hdfff, 16'hbfff,
    16'h7fff, 16'h0fff, 16'h0bff, 16'h07ff, 16'h03ff};

  // Command codes.
  localparam logic [1:0] OP_PROGRAM   = 2'h0;
  localparam logic [1:0] OP_BLK_ERASE = 2'h1;
  localparam logic [1:0] OP_ALL_ERASE = 2'h2;

  // Strap codes sampled while reset is held.
  localparam logic [1:0] MD_PROGRAMMER = 2'h0;
  localparam logic [2:0] AUX_BOOT      = 3'h3;
  localparam logic [2:0] AUX_UPROG     = 3'h5;

  typedef enum logic [1:0] {
    MODE_USER       = 2'h0,
    MODE_BOOT       = 2'h1,
    MODE_UPROG      = 2'h2,
    MODE_PROGRAMMER = 2'h3
  } ofp_mode_e;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LOAD  = 2'b01,
    ST_PROG  = 2'b11,
    ST_ERASE = 2'b10
  } ofp_state_e;

  typedef enum logic [1:0] {
    AB_ARM  = 2'b00,
    AB_IDLE = 2'b01,
    AB_LOW  = 2'b11,
    AB_LOCK = 2'b10
  } ofp_baud_e;

endpackage : ofp_pkg

/* File: verification/ofp_host_link.sv */
// Behavioural host on the boot serial link, sending one bit-rate probe.
module ofp_host_link
  import ofp_pkg::*;
(
  // Clock.
  input  wire logic        ref_clk,
  // Bench control.
  input  wire logic        go,
  input  wire logic [15:0] bit_clks,
  // Link.
  output logic             boot_serial_rx
);
  timeunit 1ns;
  timeprecision 1ps;

  // The line is driven from one process only; it goes high at the first edge.
  int cnt = 0;

  // A zero character is start bit plus eight data bits, all low.
  // The line idles high between frames, as a pulled-up line would.
  always @(posedge ref_clk)
  begin
    if (go && cnt == 0)
      cnt <= 9 * int'(bit_clks);
    else if (cnt != 0)
      cnt <= cnt - 1;
    boot_serial_rx <= !(go || cnt > 1);
  end
endmodule : ofp_host_link

/* File: verification/onchip_flash_program_erase_ctrl_bench.sv */
// Self-checking bench for the flash program/erase control.
module onchip_flash_program_erase_ctrl_bench
  import ofp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        ref_clk = 1'b0, reset = 1'b1, boot_serial_rx, boot_serial_tx;
  logic        flash_reg_enable = 1'b0, swe_wr = 1'b0, swe_wdata = 1'b0;
  logic        cmd_valid = 1'b0, pd_valid = 1'b0, host_go = 1'b0, r;
  logic        cmd_ready, cmd_refused, op_done, pd_ready, flash_error;
  logic        software_write_enable, boot_ready, baud_locked;
  logic [1:0]  md = 2'h1, cmd_op = 2'h0;
  logic [2:0]  aux = 3'h0, cmd_block = 3'h0;
  logic [8:0]  cmd_page = 9'h0;
  logic [7:0]  pd_data = 8'h0, rd_data, d;
  logic [7:0]  pa [128], pb [128];
  logic [15:0] rd_addr = 16'h0, host_bits = 16'h0;
  logic [19:0] baud_period;
  ofp_mode_e   mode;
  int          error_cnt = 0, checks_done = 0, n;
  int          blks [4] = '{0, 2, 3, 6};

  always #4 ref_clk = ~ref_clk;

  ofp_flash_ctrl #(.BAUD_CNT_W(20), .COPY_CYC(2)) ofp_flash_ctrl_inst (
    .ref_clk, .reset, .mode_select_pin_1(md[1]), .mode_select_pin_0(md[0]),
    .aux_mode_pin_2(aux[2]), .aux_mode_pin_1(aux[1]), .aux_mode_pin_0(aux[0]),
    .boot_serial_rx, .boot_serial_tx, .flash_reg_enable, .swe_wr, .swe_wdata,
    .cmd_valid, .cmd_op, .cmd_block, .cmd_page, .cmd_ready, .cmd_refused,
    .op_done, .pd_valid, .pd_data, .pd_ready, .rd_addr, .rd_data, .mode,
    .software_write_enable, .flash_error, .boot_ready, .baud_locked,
    .baud_period);

  ofp_host_link ofp_host_link_inst (.ref_clk, .go(host_go),
    .bit_clks(host_bits), .boot_serial_rx);

  task automatic print_verdict();
    if (error_cnt == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wait_hi(ref logic s, input int lim, output int cyc);
    cyc = 0;
    while (s !== 1'b1 && cyc < lim)
    begin
      @(posedge ref_clk);
      #1;
      cyc++;
    end
    if (s !== 1'b1)
    begin
      error_cnt++;
      print_verdict();
    end
  endtask : wait_hi

  function automatic int blk_bytes(input int b);
    if (b < 4)
      return 1024;
    return b == 4 ? 28 * 1024 : (b == 5 ? 16 * 1024 : 8 * 1024);
  endfunction : blk_bytes

  // Mode straps are only looked at while reset is held.
  task automatic do_reset(input logic [1:0] m, input logic [2:0] a);
    @(posedge ref_clk);
    reset <= 1'b1;
    md <= m;
    aux <= a;
    flash_reg_enable <= 1'b0;
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    #1 chk(software_write_enable, 0);
  endtask : do_reset

  task automatic set_swe(input logic en, input logic v);
    @(posedge ref_clk);
    flash_reg_enable <= en;
    swe_wr <= 1'b1;
    swe_wdata <= v;
    @(posedge ref_clk);
    swe_wr <= 1'b0;
    #1;
  endtask : set_swe

  task automatic cmd(input logic [1:0] op, input logic [2:0] blk,
                     input logic [8:0] pg, output logic rf);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_block <= blk;
    cmd_page <= pg;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    #1 rf = cmd_refused;
  endtask : cmd

  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    rd_addr <= a;
    @(posedge ref_clk);
    #1 v = rd_data;
  endtask : rd

  // Bytes are offered with random gaps so the load stage must stall.
  task automatic prog(input logic [8:0] pg, input logic [7:0] dat [128],
                      output logic rf);
    int   k;
    int   g;
    logic go;
    logic rdy;
    k = 0;
    g = 0;
    go = 1'b0;
    rdy = 1'b0;
    cmd(OP_PROGRAM, 3'h0, pg, rf);
    while (!rf && k < 128 && g < 3000)
    begin
      @(posedge ref_clk);
      if (go && rdy)
        k++;
      go = k < 128 && $urandom_range(3) != 0;
      pd_valid <= go;
      pd_data <= dat[k[6:0]];
      #1 rdy = pd_ready;
      g++;
    end
    if (g >= 3000)
    begin
      error_cnt++;
      print_verdict();
    end
  endtask : prog

  task automatic cmp_page(input logic [15:0] a, input logic [7:0] dat [128]);
    logic [7:0] v;
    for (int k = 0; k < 128; k++)
    begin
      rd(a + 16'(k), v);
      chk(v, dat[k]);
    end
  endtask : cmp_page

  initial
  begin
    void'($urandom(52366));
    for (int i = 0; i < 128; i++)
    begin
      pa[i] = 8'($urandom);
      pb[i] = 8'($urandom);
    end
    do_reset(2'h1, 3'h3);
    chk(32'(mode), 32'(MODE_BOOT));
    set_swe(1'b0, 1'b1);
    chk(software_write_enable, 0);
    set_swe(1'b1, 1'b1);
    chk(software_write_enable, 1);
    cmd(OP_ALL_ERASE, 3'h0, 9'h0, r);
    chk(r, 1);
    @(posedge ref_clk);
    host_bits <= 16'(10 + $urandom_range(30));
    host_go <= 1'b1;
    @(posedge ref_clk);
    host_go <= 1'b0;
    wait_hi(baud_locked, 1000, n);
    chk(baud_period, host_bits);
    wait_hi(boot_ready, 20, n);
    cmd(OP_BLK_ERASE, 3'h1, 9'h0, r);
    chk(r, 1);
    cmd(OP_ALL_ERASE, 3'h0, 9'h0, r);
    chk(r, 0);
    wait_hi(op_done, 70000, n);
    chk(n, 65536);
    repeat (8)
    begin
      rd(16'($urandom), d);
      chk(d, 8'hff);
    end
    prog(9'h8, pa, r);
    wait_hi(op_done, 300, n);
    prog(9'h7, pb, r);
    wait_hi(op_done, 300, n);
    cmp_page(16'h0400, pa);
    cmp_page(16'h0380, pb);
    rd(16'h0480, d);
    chk(d, 8'hff);
    // Writing over a unit that is no longer blank must trip the error lock.
    prog(9'h8, pb, r);
    wait_hi(cmd_ready, 400, n);
    rd(16'h0400, d);
    chk(d, pa[0]);
    chk(flash_error, 1);
    prog(9'h10, pa, r);
    chk(r, 1);
    do_reset(2'h1, 3'h0);
    chk(32'(mode), 32'(MODE_USER));
    set_swe(1'b1, 1'b1);
    prog(9'h10, pa, r);
    chk(r, 1);
    cmd(OP_BLK_ERASE, 3'h1, 9'h0, r);
    chk(r, 1);
    rd(16'h0385, d);
    chk(d, pb[5]);
    do_reset(2'h1, 3'h5);
    chk(32'(mode), 32'(MODE_UPROG));
    prog(9'h10, pa, r);
    chk(r, 1);
    set_swe(1'b1, 1'b1);
    cmd(OP_ALL_ERASE, 3'h0, 9'h0, r);
    chk(r, 1);
    cmd(OP_BLK_ERASE, 3'h1, 9'h0, r);
    chk(r, 0);
    wait_hi(op_done, 2000, n);
    chk(n, 1024);
    rd(16'h0400, d);
    chk(d, 8'hff);
    rd(16'h03ff, d);
    chk(d, pb[127]);
    for (int i = 0; i < 4; i++)
    begin
      cmd(OP_BLK_ERASE, 3'(blks[i]), 9'h0, r);
      chk(r, 0);
      wait_hi(op_done, 9000, n);
      chk(n, blk_bytes(blks[i]));
    end
    rd(16'h0380, d);
    chk(d, 8'hff);
    prog(9'h8, pa, r);
    chk(r, 0);
    wait_hi(op_done, 300, n);
    cmp_page(16'h0400, pa);
    // Programmer mode offers no block erase, and an unknown code never starts.
    do_reset(2'h0, 3'h0);
    chk(32'(mode), 32'(MODE_PROGRAMMER));
    chk(boot_serial_tx, 1);
    set_swe(1'b1, 1'b1);
    cmd(OP_BLK_ERASE, 3'h2, 9'h0, r);
    chk(r, 1);
    cmd(2'h3, 3'h0, 9'h0, r);
    chk(r, 1);
    print_verdict();
  end
endmodule : onchip_flash_program_erase_ctrl_bench
